// ==== fbe_pkg.sv ====
// Shared constants and types for the flash block erase sequencer
package fbe_pkg;
  // Timing: the erase time as printed, and the cycle count derived from the clock
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned ERASE_TIME_US = 2000;
  localparam int unsigned ERASE_CYCLES_DEF = ERASE_TIME_US * CLK_MHZ;
  localparam int TIMER_W = 20;

  // Wishbone address and data widths
  localparam int ADR_W = 5;
  localparam int DAT_W = 32;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_CONTROL = 5'h00;
  localparam logic [ADR_W-1:0] OFS_UNLOCK = 5'h04;
  localparam logic [ADR_W-1:0] OFS_POINTER = 5'h08;
  localparam logic [ADR_W-1:0] OFS_STATUS = 5'h0c;

  // Control register bit positions
  localparam int CTL_START = 0;
  localparam int CTL_WRITE_ENABLE_BIT = 2;
  localparam int CTL_ERASE = 4;
  localparam int CTL_CONFIG_SPACE_SELECT = 6;
  localparam int CTL_PMS = 7;

  // Status register bit positions
  localparam int STS_BUSY = 0;
  localparam int STS_REFUSED = 1;

  // Unlock pattern, first and second byte
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // Table address pointer and block field
  localparam int PTR_W = 22;
  localparam int BLK_LSB = 6;
  localparam int BLK_W = 16;
  localparam logic [PTR_W-1:0] PTR_RESET = 22'h000000;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_KEY1 = 2'b01,
    ST_ARMED = 2'b10,
    ST_ERASE = 2'b11
  } fbe_state_type;
endpackage

// ==== fbe_prog_timer.sv ====
// Internal programming timer that ends a long write cycle
`timescale 1ns/1ns
module fbe_prog_timer
  import fbe_pkg::*;
#(
  parameter int unsigned CYCLES = ERASE_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  output logic done_o
);
  logic [TIMER_W-1:0] cnt_reg; // Elapsed cycles
  logic [TIMER_W-1:0] cnt_next;
  logic run_reg; // Timer running
  logic run_next;
  logic done_reg; // One-cycle end pulse
  logic done_next;

  // Next-state of the counter; a start while running restarts it
  always_comb
  begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    done_next = 1'b0;
    if (start_i)
    begin
      cnt_next = '0;
      run_next = 1'b1;
    end
    else if (run_reg)
    begin
      if (cnt_reg == TIMER_W'(CYCLES - 1))
      begin
        run_next = 1'b0;
        done_next = 1'b1;
      end
      else
      begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end

  assign done_o = done_reg;
endmodule // fbe_prog_timer

// ==== fbe_erase_seq.sv ====
// Flash block erase sequencer with Wishbone register access
`timescale 1ns/1ns
module fbe_erase_seq
  import fbe_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Processor and flash array
  output logic cpu_stall_o,
  output logic flash_erase_o,
  output logic [BLK_W-1:0] flash_block_o
);
  // Address match, used for every register
  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
    hit = (adr == ofs);
  endfunction

  fbe_state_type state_reg; // Sequencer state
  fbe_state_type state_next;
  logic ack_reg; // Bus answer
  logic ack_next;
  logic [DAT_W-1:0] rdat_reg; // Read data
  logic [DAT_W-1:0] rdat_next;
  logic program_memory_select_reg; // Target program flash
  logic program_memory_select_next;
  logic config_space_select_reg; // Target config space
  logic config_space_select_next;
  logic write_enable_bit_reg; // Writes allowed
  logic write_enable_bit_next;
  logic erase_select_reg; // Start means erase
  logic erase_select_next;
  logic refused_reg; // Sticky: a start was refused outside an erase
  logic refused_next;
  logic [PTR_W-1:0] table_address_pointer_reg; // Table pointer
  logic [PTR_W-1:0] table_address_pointer_next;
  logic [BLK_W-1:0] block_reg; // Block under erase
  logic [BLK_W-1:0] block_next;
  logic busy_reg; // Long write in progress
  logic busy_next;
  logic take; // Request taken this edge
  logic wr_lo; // Write with the low byte lane
  logic timer_start; // Kick the programming timer
  logic timer_done; // Timer expired

  // Bus request decode; ack_reg blocks a second take of the same request
  assign take = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_lo = take && wb_we_i && wb_sel_i[0];

  // Programming timer
  fbe_prog_timer #(
    .CYCLES(ERASE_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(timer_start),
    .done_o(timer_done)
  );

  // Next values of control bits, pointer and status
  always_comb
  begin
    program_memory_select_next = program_memory_select_reg;
    config_space_select_next = config_space_select_reg;
    write_enable_bit_next = write_enable_bit_reg;
    erase_select_next = erase_select_reg;
    table_address_pointer_next = table_address_pointer_reg;
    refused_next = refused_reg;
    // Control bits take the low byte lane
    if (wr_lo && hit(wb_adr_i, OFS_CONTROL))
    begin
      program_memory_select_next = wb_dat_i[CTL_PMS];
      config_space_select_next = wb_dat_i[CTL_CONFIG_SPACE_SELECT];
      write_enable_bit_next = wb_dat_i[CTL_WRITE_ENABLE_BIT];
      erase_select_next = wb_dat_i[CTL_ERASE];
    end
    // Pointer written byte by byte
    if (take && wb_we_i && hit(wb_adr_i, OFS_POINTER))
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wb_sel_i[i])
        begin
          for (int b = 0; b < 8; b++)
          begin
            if (i * 8 + b < PTR_W)
            begin
              table_address_pointer_next[i * 8 + b] = wb_dat_i[i * 8 + b];
            end
          end
        end
      end
    end
    // Refused flag: write one to clear, a new refusal wins
    if (wr_lo && hit(wb_adr_i, OFS_STATUS) && wb_dat_i[STS_REFUSED])
    begin
      refused_next = 1'b0;
    end
    if (wr_lo && hit(wb_adr_i, OFS_CONTROL) && wb_dat_i[CTL_START] && state_reg != ST_ERASE
        && state_next != ST_ERASE)
    begin
      refused_next = 1'b1;
    end
  end

  // Unlock and erase sequencing
  always_comb
  begin
    state_next = state_reg;
    busy_next = busy_reg;
    block_next = block_reg;
    timer_start = 1'b0;
    case (state_reg)
      ST_IDLE, ST_KEY1, ST_ARMED:
      begin
        if (take && wb_we_i)
        begin
          // Any other write breaks the chain
          state_next = ST_IDLE;
          if (wb_sel_i[0] && hit(wb_adr_i, OFS_UNLOCK))
          begin
            if (wb_dat_i[7:0] == KEY_FIRST)
            begin
              state_next = ST_KEY1;
            end
            else if (wb_dat_i[7:0] == KEY_SECOND && state_reg == ST_KEY1)
            begin
              state_next = ST_ARMED;
            end
          end
          else if (wb_sel_i[0] && hit(wb_adr_i, OFS_CONTROL) && wb_dat_i[CTL_START]
                   && state_reg == ST_ARMED && wb_dat_i[CTL_WRITE_ENABLE_BIT] && wb_dat_i[CTL_ERASE]
                   && wb_dat_i[CTL_PMS] && !wb_dat_i[CTL_CONFIG_SPACE_SELECT])
          begin
            // Only a single block erase exists; programming is not handled here
            state_next = ST_ERASE;
            busy_next = 1'b1;
            timer_start = 1'b1;
            block_next = table_address_pointer_reg[PTR_W-1:BLK_LSB];
          end
        end
      end
      ST_ERASE:
      begin
        // Only the timer ends the cycle; starts are ignored meanwhile
        if (timer_done)
        begin
          state_next = ST_IDLE;
          busy_next = 1'b0;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        busy_next = 1'b0;
      end
    endcase
  end

  // Bus answer and read data; unmapped offsets read zero
  always_comb
  begin
    ack_next = take;
    rdat_next = rdat_reg;
    if (take && !wb_we_i)
    begin
      rdat_next = '0;
      if (hit(wb_adr_i, OFS_CONTROL))
      begin
        rdat_next[CTL_PMS] = program_memory_select_reg;
        rdat_next[CTL_CONFIG_SPACE_SELECT] = config_space_select_reg;
        rdat_next[CTL_WRITE_ENABLE_BIT] = write_enable_bit_reg;
        rdat_next[CTL_ERASE] = erase_select_reg;
        rdat_next[CTL_START] = busy_reg;
      end
      else if (hit(wb_adr_i, OFS_POINTER))
      begin
        rdat_next[PTR_W-1:0] = table_address_pointer_reg;
      end
      else if (hit(wb_adr_i, OFS_STATUS))
      begin
        rdat_next[STS_BUSY] = busy_reg;
        rdat_next[STS_REFUSED] = refused_reg;
      end
    end
  end

  // All registers except the stall counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      ack_reg <= 1'b0;
      rdat_reg <= '0;
      program_memory_select_reg <= 1'b0;
      config_space_select_reg <= 1'b0;
      write_enable_bit_reg <= 1'b0;
      erase_select_reg <= 1'b0;
      refused_reg <= 1'b0;
      table_address_pointer_reg <= PTR_RESET;
      block_reg <= '0;
      busy_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      program_memory_select_reg <= program_memory_select_next;
      config_space_select_reg <= config_space_select_next;
      write_enable_bit_reg <= write_enable_bit_next;
      erase_select_reg <= erase_select_next;
      refused_reg <= refused_next;
      table_address_pointer_reg <= table_address_pointer_next;
      block_reg <= block_next;
      busy_reg <= busy_next;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign cpu_stall_o = busy_reg;
  assign flash_erase_o = busy_reg;
  assign flash_block_o = block_reg;

  // Helper: cycles spent stalled, saturating
  logic [TIMER_W:0] stall_cnt;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !busy_reg)
    begin
      stall_cnt <= '0;
    end
    else if (!(&stall_cnt))
    begin
      stall_cnt <= stall_cnt + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_next_cycle_a: assert property (take |=> wb_ack_o) else $error("ack missing after request");
  start_after_unlock_a: assert property ($rose(busy_reg) |-> $past(state_reg) == ST_ARMED)
    else $error("erase began without unlock");
  start_needs_write_enable_bit_a: assert property ($rose(busy_reg) |-> write_enable_bit_reg)
    else $error("erase began with write enable clear");
  start_is_erase_a: assert property ($rose(busy_reg) |-> erase_select_reg && program_memory_select_reg)
    else $error("erase began without erase select");
  block_from_ptr_a: assert property ($rose(busy_reg) |-> flash_block_o == $past(table_address_pointer_reg[PTR_W-1:BLK_LSB]))
    else $error("wrong block address");
  block_held_a: assert property (busy_reg && $past(busy_reg) |-> $stable(flash_block_o))
    else $error("block changed during erase");
  stall_held_a: assert property (busy_reg && stall_cnt < (TIMER_W+1)'(ERASE_CYCLES) |=> busy_reg)
    else $error("stall ended early");
  stall_end_a: assert property ($fell(busy_reg) |-> $past(stall_cnt) >= (TIMER_W+1)'(ERASE_CYCLES))
    else $error("erase shorter than timer");
  stall_bound_a: assert property (stall_cnt <= (TIMER_W+1)'(ERASE_CYCLES + 2))
    else $error("erase longer than timer");

  erase_start_c: cover property ($rose(busy_reg));
  erase_end_c: cover property ($fell(busy_reg));
  refused_c: cover property ($rose(refused_reg));
  armed_c: cover property (state_reg == ST_ARMED);
endmodule // fbe_erase_seq

// ==== fbe_flash_model.sv ====
// Behavioural model of the flash array erased by the sequencer
`timescale 1ns/1ns
module fbe_flash_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Erase request from the sequencer
  input wire logic erase_i,
  input wire logic [15:0] block_i,
  // Observations for the bench
  output int erase_count_o,
  output int last_len_o,
  output logic [15:0] last_block_o,
  output int bad_count_o
);
  int len; // Cycles of the erase now running
  // Array only knows whole blocks, one per request
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      erase_count_o <= 0;
      last_len_o <= 0;
      last_block_o <= 16'h0000;
      bad_count_o <= 0;
      len <= 0;
    end
    else if (erase_i)
    begin
      // A block that moves mid-erase would tear two blocks
      if (len != 0 && block_i !== last_block_o)
        bad_count_o <= bad_count_o + 1;
      if (len == 0)
      begin
        last_block_o <= block_i;
        erase_count_o <= erase_count_o + 1;
      end
      len <= len + 1;
    end
    else if (len != 0)
    begin
      // Erase done, remember its length
      last_len_o <= len;
      len <= 0;
    end
  end
endmodule // fbe_flash_model

// ==== fbe_erase_seq_tb.sv ====
// Self-checking bench for the flash block erase sequencer
`timescale 1ns/1ns
module fbe_erase_seq_tb;
  import fbe_pkg::*;
  localparam int unsigned EC = 20; // Short erase for simulation
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [DAT_W-1:0] wb_dat_i = '0;
  logic [DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic cpu_stall_o;
  logic flash_erase_o;
  logic [BLK_W-1:0] flash_block_o;
  int erase_count, last_len, bad_count, n_fail = 0, check_count = 0;
  logic [15:0] last_block;
  logic [31:0] rd;
  // Refusal table: keys, control data, pointer write in between
  logic [7:0] rk1 [6] = '{8'h55, 8'h55, 8'h55, 8'h55, 8'haa, 8'h55};
  logic [7:0] rk2 [6] = '{8'haa, 8'haa, 8'haa, 8'haa, 8'h55, 8'haa};
  logic [7:0] rct [6] = '{8'h91, 8'h85, 8'hd5, 8'h15, 8'h95, 8'h95};
  bit rmid [6] = '{0, 0, 0, 0, 0, 1};
  logic [21:0] ptrs [2] = '{22'h2abc3f, 22'h00003f};

  always #2 clk_i = ~clk_i;

  fbe_erase_seq #(.ERASE_CYCLES(EC)) fbe_erase_seq_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_stall_o(cpu_stall_o), .flash_erase_o(flash_erase_o),
    .flash_block_o(flash_block_o));
  fbe_flash_model fbe_flash_model_inst (.clk_i(clk_i), .rst_i(rst_i), .erase_i(flash_erase_o),
    .block_i(flash_block_o), .erase_count_o(erase_count), .last_len_o(last_len),
    .last_block_o(last_block), .bad_count_o(bad_count));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    // No latency assumed; only the watchdog ends a wait that never answers
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Unlock pair, optional stray write, then the start write
  task automatic seq(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] ctl, input bit mid);
    wb(1'b1, OFS_UNLOCK, {24'h0, k1});
    wb(1'b1, OFS_UNLOCK, {24'h0, k2});
    if (mid)
      wb(1'b1, OFS_POINTER, 32'h0);
    wb(1'b1, OFS_CONTROL, {24'h0, ctl});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog, well beyond the few hundred cycles needed
  initial
  begin
    #(20000 * 4);
    chk(1'b0, 1'b1);
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values and an unmapped place
    wb(1'b0, OFS_CONTROL, 32'h0); chk(rd, 32'h0);
    wb(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h0);
    wb(1'b1, 5'h10, 32'hffffffff);
    wb(1'b0, 5'h10, 32'h0); chk(rd, 32'h0);
    $display("test reset done");
    // Good erases, low pointer bits set so they must be dropped
    foreach (ptrs[i])
    begin
      wb(1'b1, OFS_POINTER, {10'h0, ptrs[i]});
      wb(1'b0, OFS_POINTER, 32'h0); chk(rd, {10'h0, ptrs[i]});
      wb(1'b1, OFS_CONTROL, 32'h94);
      wb(1'b0, OFS_CONTROL, 32'h0); chk(rd, 32'h94);
      seq(8'h55, 8'haa, 8'h95, 0);
      wb(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h1);
      wb(1'b0, OFS_CONTROL, 32'h0); chk(rd, 32'h95);
      chk(cpu_stall_o, 1'b1);
      chk(flash_block_o, ptrs[i][21:6]);
      seq(8'h55, 8'haa, 8'h95, 0);
      wait (cpu_stall_o === 1'b0 || $time > 60000);
      // Model stores the length one edge after the fall; look one edge later still
      repeat (2) @(posedge clk_i);
      chk(erase_count, i + 1);
      chk(last_len, EC + 1);
      chk(last_block, ptrs[i][21:6]);
    end
    $display("test erase done");
    // Each missing condition or a broken chain must refuse
    foreach (rct[i])
    begin
      seq(rk1[i], rk2[i], rct[i], rmid[i]);
      repeat (3) @(posedge clk_i);
      chk(cpu_stall_o, 1'b0);
      wb(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h2);
      wb(1'b1, OFS_STATUS, 32'h2);
      wb(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h0);
    end
    chk(erase_count, 2);
    chk(bad_count, 0);
    $display("test refuse done");
    end_of_test();
  end
endmodule // fbe_erase_seq_tb
